// [muting_pkg.sv]
package muting_pkg;

  // system clock and the prescaled tick
  localparam int CLK_HZ = 250_000_000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int TICKS_PER_S = 1000 / TICK_MS;

  // documented times in their own units
  localparam int CONCUR_S = 3;
  localparam int BYPASS_MUTE_MIN = 10;
  localparam int MUTE_LIMIT_MIN = 2;
  localparam int BYPASS_FLASH_MS = 1000;
  localparam int LIMIT_FLASH_MHZ = 1500;

  // tick counts derived from the times
  localparam int CONCUR_TICKS = CONCUR_S * TICKS_PER_S;
  localparam int BYPASS_MUTE_TICKS = BYPASS_MUTE_MIN * 60 * TICKS_PER_S;
  localparam int MUTE_LIMIT_TICKS = MUTE_LIMIT_MIN * 60 * TICKS_PER_S;
  localparam int BYPASS_HALF_TICKS = BYPASS_FLASH_MS / TICK_MS / 2;
  localparam int LIMIT_HALF_TICKS = 1_000_000 / LIMIT_FLASH_MHZ / TICK_MS / 2;

  // counter widths
  localparam int PRE_W = 24;
  localparam int WIN_W = 9;
  localparam int MUTE_W = 16;
  localparam int FLASH_W = 7;

  // synchronised input bundle layout
  localparam int IN_W = 8;
  localparam int IN_SENSOR_LO = 0;
  localparam int IN_CURTAIN = 4;
  localparam int IN_MUTE_EN = 5;
  localparam int IN_LIMIT_EN = 6;
  localparam int IN_START = 7;

  // sensor indices and pair selects
  localparam int NUM_SENSORS = 4;
  localparam int PAIR_A = 0;
  localparam int PAIR_B = 1;
  // set bits mark light-on sensors (two and four), active when open
  localparam logic [3:0] LIGHT_ON_MASK = 4'hA;
  localparam logic [3:0] PAIR_A_MASK = 4'h3;
  localparam logic [3:0] PAIR_B_MASK = 4'hC;

  localparam logic [1:0] OUT_ON = 2'h3;
  localparam logic [1:0] OUT_OFF = 2'h0;

  typedef enum logic [2:0] {
    ST_INTERLOCK,
    ST_RUN,
    ST_STOP,
    ST_BYPASS,
    ST_MUTE_AUTO,
    ST_MUTE_BYPASS,
    ST_LIMIT
  } mute_state_t;

endpackage

// [input_sync.sv]
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser for a bundle of level inputs
module input_sync #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (reset) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

`default_nettype wire

// [conveyor_muting_bypass_controller.sv]
`timescale 1ns/1ps
`default_nettype none

module conveyor_muting_bypass_controller #(
  parameter int TICK_CYCLES = muting_pkg::TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [3:0] sensor_in,
  input wire logic curtain_clear,
  input wire logic mute_enable,
  input wire logic mute_limit_enable,
  input wire logic start_button,
  output logic [1:0] safety_output_pair,
  output logic mute_lamp,
  output logic muted,
  output logic bypass_allowed
);

  // both sensors of a pair active
  function automatic logic pair_both(input logic [3:0] act, input int p);
    pair_both = (p == muting_pkg::PAIR_A) ? (act[0] & act[1]) : (act[2] & act[3]);
  endfunction

  // any sensor of a pair active
  function automatic logic pair_any(input logic [3:0] act, input int p);
    pair_any = (p == muting_pkg::PAIR_A) ? (act[0] | act[1]) : (act[2] | act[3]);
  endfunction

  logic [muting_pkg::IN_W-1:0] raw_in;
  logic [muting_pkg::IN_W-1:0] syn_in;
  logic [3:0] act;
  logic curtain_ok;
  logic mute_en;
  logic limit_en;
  logic btn;
  logic any_act;

  assign raw_in = {start_button, mute_limit_enable, mute_enable, curtain_clear, sensor_in};

  input_sync #(
    .W(muting_pkg::IN_W)
  ) u_sync (
    .mclk(mclk),
    .reset(reset),
    .async_in(raw_in),
    .sync_out(syn_in)
  );

  // polarity per sensor type, then the other levels
  assign act = syn_in[muting_pkg::IN_SENSOR_LO +: muting_pkg::NUM_SENSORS]
               ^ muting_pkg::LIGHT_ON_MASK;
  assign curtain_ok = syn_in[muting_pkg::IN_CURTAIN];
  assign mute_en = syn_in[muting_pkg::IN_MUTE_EN];
  assign limit_en = syn_in[muting_pkg::IN_LIMIT_EN];
  assign btn = syn_in[muting_pkg::IN_START];
  assign any_act = |act;

  // tick prescaler
  logic [muting_pkg::PRE_W-1:0] pre_r;
  logic tick;

  assign tick = (pre_r == muting_pkg::PRE_W'(TICK_CYCLES - 1));

  always_ff @(posedge mclk) begin
    if (reset) begin
      pre_r <= '0;
    end else if (tick) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 1'b1;
    end
  end

  // start button: press seen on a tick, taken on release
  logic seen_r;
  logic start_press;

  assign start_press = seen_r & ~btn;

  always_ff @(posedge mclk) begin
    if (reset) begin
      seen_r <= 1'b0;
    end else if (!btn) begin
      seen_r <= 1'b0;
    end else if (tick) begin
      seen_r <= 1'b1;
    end
  end

  // pair concurrence windows
  logic [muting_pkg::WIN_W-1:0] win_r [2];
  logic [1:0] ok_r;
  logic [1:0] bad_r;
  logic [1:0] ok_now;

  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int p = 0; p < 2; p++) begin
        win_r[p] <= '0;
      end
      ok_r <= '0;
      bad_r <= '0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (!pair_any(act, p)) begin
          win_r[p] <= '0;
          ok_r[p] <= 1'b0;
          bad_r[p] <= 1'b0;
        end else if (pair_both(act, p)) begin
          if (!bad_r[p]) begin
            ok_r[p] <= 1'b1;
          end
        end else if (!ok_r[p] && tick) begin
          if (win_r[p] >= muting_pkg::WIN_W'(muting_pkg::CONCUR_TICKS - 1)) begin
            bad_r[p] <= 1'b1;
          end else begin
            win_r[p] <= win_r[p] + 1'b1;
          end
        end
      end
    end
  end

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      ok_now[p] = ok_r[p] & pair_both(act, p);
    end
  end

  // auto mute arming: only after all sensors have been clear
  logic arm_r;
  muting_pkg::mute_state_t state_r;
  muting_pkg::mute_state_t state_nxt;
  logic entering_mute;

  assign entering_mute = (state_nxt == muting_pkg::ST_MUTE_AUTO ||
                          state_nxt == muting_pkg::ST_MUTE_BYPASS) &&
                         state_nxt != state_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      arm_r <= 1'b0;
    end else if (entering_mute) begin
      arm_r <= 1'b0;
    end else if (!any_act) begin
      arm_r <= 1'b1;
    end
  end

  // sequence tracking inside automatic muting
  logic lead_r;
  logic handed_r;
  logic [3:0] dropped_r;
  logic lead_nxt;
  logic seq_lost;
  logic seq_done;
  logic [3:0] lead_mask;
  int trail;
  int lead;

  assign lead = lead_r ? muting_pkg::PAIR_B : muting_pkg::PAIR_A;
  assign trail = lead_r ? muting_pkg::PAIR_A : muting_pkg::PAIR_B;
  assign lead_mask = lead_r ? muting_pkg::PAIR_B_MASK : muting_pkg::PAIR_A_MASK;

  // leader must hold until handover, then dropped sensors stay out
  always_comb begin
    seq_lost = 1'b0;
    seq_done = 1'b0;
    if (!handed_r) begin
      seq_lost = ~pair_both(act, lead) & ~ok_now[trail];
    end else begin
      seq_lost = |(dropped_r & act);
      seq_done = ~pair_both(act, trail);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      lead_r <= 1'b0;
      handed_r <= 1'b0;
      dropped_r <= '0;
    end else if (state_r != muting_pkg::ST_MUTE_AUTO) begin
      lead_r <= lead_nxt;
      handed_r <= 1'b0;
      dropped_r <= '0;
    end else if (!handed_r) begin
      if (ok_now[trail]) begin
        handed_r <= 1'b1;
      end
    end else begin
      dropped_r <= dropped_r | (lead_mask & ~act);
    end
  end

  // muting timer, restarted on every mute entry
  logic [muting_pkg::MUTE_W-1:0] mute_t_r;
  logic bypass_over;
  logic limit_over;

  assign bypass_over = (mute_t_r >= muting_pkg::MUTE_W'(muting_pkg::BYPASS_MUTE_TICKS));
  assign limit_over = (mute_t_r >= muting_pkg::MUTE_W'(muting_pkg::MUTE_LIMIT_TICKS));

  always_ff @(posedge mclk) begin
    if (reset) begin
      mute_t_r <= '0;
    end else if (entering_mute) begin
      mute_t_r <= '0;
    end else if (tick && (state_r == muting_pkg::ST_MUTE_AUTO ||
                          state_r == muting_pkg::ST_MUTE_BYPASS) && !bypass_over) begin
      mute_t_r <= mute_t_r + 1'b1;
    end
  end

  // state transitions
  always_comb begin
    state_nxt = state_r;
    lead_nxt = lead_r;
    case (state_r)
      muting_pkg::ST_INTERLOCK: begin
        if (start_press && curtain_ok) begin
          state_nxt = muting_pkg::ST_RUN;
        end
      end
      muting_pkg::ST_RUN: begin
        if (mute_en && arm_r && ok_now[muting_pkg::PAIR_A] &&
            !pair_any(act, muting_pkg::PAIR_B)) begin
          state_nxt = muting_pkg::ST_MUTE_AUTO;
          lead_nxt = 1'b0;
        end else if (mute_en && arm_r && ok_now[muting_pkg::PAIR_B] &&
                     !pair_any(act, muting_pkg::PAIR_A)) begin
          state_nxt = muting_pkg::ST_MUTE_AUTO;
          lead_nxt = 1'b1;
        end else if (!curtain_ok) begin
          state_nxt = muting_pkg::ST_STOP;
        end
      end
      muting_pkg::ST_STOP: begin
        if (any_act) begin
          state_nxt = muting_pkg::ST_BYPASS;
        end else if (start_press && curtain_ok) begin
          state_nxt = muting_pkg::ST_RUN;
        end
      end
      muting_pkg::ST_BYPASS, muting_pkg::ST_LIMIT: begin
        if (!any_act) begin
          state_nxt = muting_pkg::ST_STOP;
        end else if (start_press) begin
          state_nxt = muting_pkg::ST_MUTE_BYPASS;
        end
      end
      muting_pkg::ST_MUTE_AUTO: begin
        if (!mute_en || seq_lost || seq_done) begin
          state_nxt = curtain_ok ? muting_pkg::ST_RUN : muting_pkg::ST_STOP;
        end else if (limit_en && limit_over) begin
          state_nxt = muting_pkg::ST_LIMIT;
        end
        // limit off: muting lasts while the sequence holds
      end
      muting_pkg::ST_MUTE_BYPASS: begin
        if (curtain_ok) begin
          state_nxt = muting_pkg::ST_RUN;
        end else if (!any_act) begin
          state_nxt = muting_pkg::ST_STOP;
        end else if (bypass_over) begin
          state_nxt = muting_pkg::ST_BYPASS;
        end
      end
      default: begin
        state_nxt = muting_pkg::ST_INTERLOCK;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r <= muting_pkg::ST_INTERLOCK;
    end else begin
      state_r <= state_nxt;
    end
  end

  // lamp flash phase, restarted on state change
  logic [muting_pkg::FLASH_W-1:0] flash_t_r;
  logic flash_r;
  logic [muting_pkg::FLASH_W-1:0] half_ticks;

  assign half_ticks = (state_r == muting_pkg::ST_LIMIT) ?
                      muting_pkg::FLASH_W'(muting_pkg::LIMIT_HALF_TICKS) :
                      muting_pkg::FLASH_W'(muting_pkg::BYPASS_HALF_TICKS);

  always_ff @(posedge mclk) begin
    if (reset) begin
      flash_t_r <= '0;
      flash_r <= 1'b0;
    end else if (state_nxt != state_r) begin
      flash_t_r <= '0;
      flash_r <= 1'b1;
    end else if (tick) begin
      if (flash_t_r >= half_ticks - 1'b1) begin
        flash_t_r <= '0;
        flash_r <= ~flash_r;
      end else begin
        flash_t_r <= flash_t_r + 1'b1;
      end
    end
  end

  // registered outputs
  always_ff @(posedge mclk) begin
    if (reset) begin
      safety_output_pair <= muting_pkg::OUT_OFF;
      mute_lamp <= 1'b0;
      muted <= 1'b0;
      bypass_allowed <= 1'b0;
    end else begin
      case (state_r)
        muting_pkg::ST_RUN: begin
          safety_output_pair <= muting_pkg::OUT_ON;
          mute_lamp <= 1'b0;
          muted <= 1'b0;
          bypass_allowed <= 1'b0;
        end
        muting_pkg::ST_MUTE_AUTO, muting_pkg::ST_MUTE_BYPASS: begin
          safety_output_pair <= muting_pkg::OUT_ON;
          mute_lamp <= 1'b1;
          muted <= 1'b1;
          bypass_allowed <= 1'b0;
        end
        muting_pkg::ST_BYPASS, muting_pkg::ST_LIMIT: begin
          safety_output_pair <= muting_pkg::OUT_OFF;
          mute_lamp <= flash_r;
          muted <= 1'b0;
          bypass_allowed <= 1'b1;
        end
        default: begin
          safety_output_pair <= muting_pkg::OUT_OFF;
          mute_lamp <= 1'b0;
          muted <= 1'b0;
          bypass_allowed <= 1'b0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// [muting_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module muting_asserts #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [3:0] sensor_in,
  input wire logic curtain_clear,
  input wire logic mute_enable,
  input wire logic mute_limit_enable,
  input wire logic start_button,
  input wire logic [1:0] safety_output_pair,
  input wire logic mute_lamp,
  input wire logic muted,
  input wire logic bypass_allowed
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic [3:0] act;
  logic [15:0] hold_r;
  logic lamp_r;
  // sensors decoded to active high
  assign act = sensor_in ^ 4'hA;
  // cycles the flashing lamp has held its level
  always_ff @(posedge mclk) begin
    lamp_r <= mute_lamp;
    if (reset || !bypass_allowed || mute_lamp != lamp_r) begin
      hold_r <= 16'h0000;
    end else begin
      hold_r <= hold_r + 16'h0001;
    end
  end
  a_reset_outputs_off: assert property ($past(reset) |-> safety_output_pair == 2'h0
    && !muted && !bypass_allowed && !mute_lamp) else $error("outputs not off after reset");
  a_muted_outputs_on: assert property (muted |-> safety_output_pair == 2'h3 && mute_lamp)
    else $error("muting without outputs on and lamp lit");
  a_bypass_outputs_off: assert property (bypass_allowed |-> safety_output_pair == 2'h0
    && !muted) else $error("bypass shown with outputs on");
  a_idle_lamp_dark: assert property (!muted && !bypass_allowed |-> !mute_lamp)
    else $error("lamp lit outside muting and bypass");
  a_flash_min_hold: assert property (bypass_allowed && $past(bypass_allowed)
    && mute_lamp != lamp_r |-> hold_r >= 16 * TICK_CYCLES) else $error("lamp flashes too fast");
  a_flash_max_hold: assert property (hold_r <= 52 * TICK_CYCLES)
    else $error("lamp stopped flashing");
  a_mute_needs_sensor: assert property (muted |-> ($past(act, 4) | $past(act, 5)) != 4'h0)
    else $error("muted with all sensors clear");
  a_start_on_release: assert property ($rose(safety_output_pair == 2'h3)
    |-> !$past(start_button, 2) && !$past(start_button, 3)) else $error("start before release");
  a_run_needs_clear: assert property ($rose(safety_output_pair == 2'h3) && !muted
    |-> $past(curtain_clear, 2)) else $error("run entered with curtain blocked");
  c_muted: cover property ($rose(muted));
  c_bypass: cover property ($rose(bypass_allowed) && !$past(muted));
  c_limit: cover property ($rose(bypass_allowed) && $past(muted));
endmodule
bind conveyor_muting_bypass_controller muting_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .mclk(mclk), .reset(reset), .sensor_in(sensor_in), .curtain_clear(curtain_clear),
  .mute_enable(mute_enable), .mute_limit_enable(mute_limit_enable),
  .start_button(start_button), .safety_output_pair(safety_output_pair),
  .mute_lamp(mute_lamp), .muted(muted), .bypass_allowed(bypass_allowed));
`default_nettype wire

// [conveyor_field_model.sv]
`timescale 1ns/1ps
`default_nettype none
module conveyor_field_model (
  input wire logic mclk,
  output logic [3:0] sensor_in,
  output logic curtain_clear,
  output logic start_button
);
  logic [3:0] act_r = 4'h0;
  logic clear_r = 1'b1;
  logic press_r = 1'b0;
  // sensors two and four read active when open
  assign sensor_in = act_r ^ 4'hA;
  assign curtain_clear = clear_r;
  assign start_button = press_r;
  // new sensor picture after a wait, then settle
  task automatic put_sensors(input logic [3:0] a, input logic c, input int pre);
    repeat (pre + 1) @(posedge mclk);
    #1;
    act_r = a;
    clear_r = c;
    repeat (8) @(posedge mclk);
    #1;
  endtask
  // supervisor press held n cycles, then released
  task automatic press_start(input int n);
    @(posedge mclk);
    #1;
    press_r = 1'b1;
    repeat (n) @(posedge mclk);
    #1;
    press_r = 1'b0;
    repeat (8) @(posedge mclk);
    #1;
  endtask
endmodule
`default_nettype wire

// [conveyor_muting_bypass_controller_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module conveyor_muting_bypass_controller_tb_top;
  localparam int TICK = 1; // tick every cycle so the ten-minute bypass limit fits the run
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic mute_enable = 1'b0;
  logic mute_limit_enable = 1'b0;
  logic [3:0] sensor_in;
  logic curtain_clear;
  logic start_button;
  logic [1:0] safety_output_pair;
  logic mute_lamp;
  logic muted;
  logic bypass_allowed;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  int seed = 19;
  int waited;
  // model outputs per state: off, run, muting, bypass
  logic [1:0] exp_safety [4] = '{2'h0, 2'h3, 2'h3, 2'h0};
  logic exp_muted [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
  logic exp_bypass [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
  conveyor_field_model fm (.mclk(mclk), .sensor_in(sensor_in),
    .curtain_clear(curtain_clear), .start_button(start_button));
  conveyor_muting_bypass_controller #(.TICK_CYCLES(TICK)) dut_u (.mclk(mclk), .reset(reset),
    .sensor_in(sensor_in), .curtain_clear(curtain_clear), .mute_enable(mute_enable),
    .mute_limit_enable(mute_limit_enable), .start_button(start_button),
    .safety_output_pair(safety_output_pair), .mute_lamp(mute_lamp), .muted(muted),
    .bypass_allowed(bypass_allowed));
  // clock and hang guard
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // wait up to lim cycles for the modelled state, then compare
  task automatic expect_st(input int s, input int lim);
    waited = 0;
    while (waited < lim && (safety_output_pair !== exp_safety[s]
        || muted !== exp_muted[s] || bypass_allowed !== exp_bypass[s])) begin
      @(posedge mclk);
      #1;
      waited++;
    end
    chk(safety_output_pair, exp_safety[s]);
    chk({1'b0, muted}, {1'b0, exp_muted[s]});
    chk({1'b0, bypass_allowed}, {1'b0, exp_bypass[s]});
    if (s != 3) chk({1'b0, mute_lamp}, {1'b0, exp_muted[s]});
  endtask
  // count lamp toggles over a window against the expected half period
  task automatic lamp_flash(input int half);
    int t;
    logic prev;
    t = 0;
    prev = mute_lamp;
    repeat (450) begin
      @(posedge mclk);
      #1;
      if (mute_lamp !== prev) t++;
      prev = mute_lamp;
    end
    chk({1'b0, t >= 450 / half - 1 && t <= 450 / half + 1}, 2'h1);
  endtask
  function automatic int gap();
    return 8 + $unsigned($random(seed)) % 200;
  endfunction
  function automatic int hold();
    return (2 + $unsigned($random(seed)) % 4) * TICK;
  endfunction
  // main sequence
  initial begin
    repeat (3) @(posedge mclk);
    #1;
    reset = 1'b0;
    expect_st(0, 0);
    fm.press_start(hold());
    expect_st(1, 20);
    mute_enable = 1'b1;
    $display("test power_up done");
    fm.put_sensors(4'h1, 1'b1, 0);
    expect_st(1, 0);
    fm.put_sensors(4'h3, 1'b1, gap());
    expect_st(2, 20);
    fm.put_sensors(4'hB, 1'b1, gap());
    fm.put_sensors(4'hF, 1'b1, gap());
    fm.put_sensors(4'hC, 1'b1, 0);
    expect_st(2, 0);
    fm.put_sensors(4'hD, 1'b1, 0);
    expect_st(1, 20);
    fm.put_sensors(4'h0, 1'b1, 0);
    $display("test forward done");
    fm.put_sensors(4'h8, 1'b1, 0);
    fm.put_sensors(4'hC, 1'b1, gap());
    expect_st(2, 20);
    fm.put_sensors(4'hD, 1'b1, gap());
    fm.put_sensors(4'hF, 1'b1, gap());
    fm.put_sensors(4'h3, 1'b1, 0);
    expect_st(2, 0);
    fm.put_sensors(4'h0, 1'b1, 0);
    expect_st(1, 20);
    $display("test reverse done");
    fm.put_sensors(4'h2, 1'b1, 0);
    fm.put_sensors(4'h3, 1'b1, 310 * TICK);
    expect_st(1, 0);
    fm.put_sensors(4'h0, 1'b1, 0);
    mute_enable = 1'b0;
    fm.put_sensors(4'h3, 1'b1, 0);
    expect_st(1, 0);
    $display("test refusals done");
    fm.put_sensors(4'h3, 1'b0, 0);
    expect_st(3, 40);
    lamp_flash(muting_pkg::BYPASS_HALF_TICKS * TICK);
    fm.press_start(hold());
    expect_st(2, 20);
    fm.put_sensors(4'h3, 1'b1, 0);
    expect_st(1, 20);
    fm.put_sensors(4'h3, 1'b0, 0);
    expect_st(3, 40);
    fm.press_start(hold());
    expect_st(2, 20);
    expect_st(3, 60100 * TICK);
    chk({1'b0, waited >= 59990 * TICK}, 2'h1);
    fm.press_start(hold());
    expect_st(2, 20);
    fm.put_sensors(4'h0, 1'b0, 0);
    expect_st(0, 20);
    fm.put_sensors(4'h0, 1'b1, 0);
    fm.press_start(hold());
    expect_st(1, 20);
    $display("test bypass done");
    mute_enable = 1'b1;
    mute_limit_enable = 1'b1;
    fm.put_sensors(4'h1, 1'b1, 0);
    fm.put_sensors(4'h3, 1'b1, gap());
    expect_st(2, 20);
    expect_st(3, 12100 * TICK);
    chk({1'b0, waited >= 11990 * TICK}, 2'h1);
    lamp_flash(muting_pkg::LIMIT_HALF_TICKS * TICK);
    fm.put_sensors(4'h0, 1'b1, 0);
    expect_st(0, 20);
    $display("test limit done");
    mute_limit_enable = 1'b0;
    fm.put_sensors(4'h4, 1'b1, 0);
    reset = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    reset = 1'b0;
    expect_st(0, 0);
    fm.press_start(hold());
    expect_st(1, 20);
    fm.put_sensors(4'h3, 1'b1, 0);
    expect_st(1, 0);
    fm.put_sensors(4'h3, 1'b0, 0);
    expect_st(3, 40);
    $display("test power_up_sensor done");
    end_of_test();
  end
endmodule
`default_nettype wire
